// >>> dv/testbench.sv
// self-checking bench for the status block
`timescale 1ns/1ps
module testbench;
    logic       clk, rst, wr, rd, rx_valid, rx_parity_err, rx_frame_err, rxd, bit_tick;
    logic       tx_busy, tx_done, cts_n, dsr_n, ring_indicator_n, carrier_detect_n;
    logic       tx_write, tx_direct, tx_halt, rx_enable, nine_bit_en, fast_ir_en;
    logic       rts_n, dtr_n, irq_line, irq_modem;
    logic [2:0] addr;
    logic [3:0] frame_bits;
    logic [7:0] wdata, rdata, rx_char, tx_level, tx_data;
    int         bad_count = 0;
    int         tests_run = 0;

    ulms_host host (.clk, .rdata, .addr, .wdata, .wr, .rd);

    ulms_status_ctrl #(.DEPTH(16)) DUT (
        .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .rx_valid, .rx_char,
        .rx_parity_err, .rx_frame_err, .rxd, .bit_tick, .frame_bits, .tx_level,
        .tx_busy, .tx_done, .cts_n, .dsr_n, .ring_indicator_n, .carrier_detect_n,
        .tx_write, .tx_direct, .tx_data, .tx_halt, .rx_enable, .nine_bit_en,
        .fast_ir_en, .rts_n, .dtr_n, .irq_line, .irq_modem
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.rd_reg(a, v);
        chk(v, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rx_push(input logic [7:0] c, input logic pe, input logic fe);
        @(posedge clk);
        rx_valid      <= 1'b1;
        rx_char       <= c;
        rx_parity_err <= pe;
        rx_frame_err  <= fe;
        @(posedge clk);
        rx_valid      <= 1'b0;
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rdc(3'h7, 8'hFF);
        rdc(3'h5, 8'h60);
        host.wr_reg(3'h7, 8'h5A);
        host.wr_reg(3'h2, 8'h11);
        rdc(3'h7, 8'h5A);
        host.wr_reg(3'h6, 8'hF0);
        wait_cyc(1);
        chk({tx_halt, rx_enable, nine_bit_en, fast_ir_en}, 8'h04);
        host.wr_reg(3'h1, 8'h01);
        host.wr_reg(3'h6, 8'hF0);
        wait_cyc(1);
        chk({tx_halt, rx_enable, nine_bit_en, fast_ir_en}, 8'h0B);
        rx_push(8'h33, 1'b0, 1'b0);
        rdc(3'h5, 8'h60);
        host.wr_reg(3'h6, 8'h00);
        wait_cyc(1);
        chk({tx_halt, rx_enable, nine_bit_en, fast_ir_en}, 8'h04);
    endtask

    task automatic t_level();
        rx_push(8'h41, 1'b0, 1'b0);
        rx_push(8'h42, 1'b0, 1'b0);
        @(posedge clk) tx_level <= 8'h07;
        host.wr_reg(3'h1, 8'h10);
        host.wr_reg(3'h7, 8'h02);
        rdc(3'h7, 8'h02);
        host.wr_reg(3'h7, 8'h01);
        rdc(3'h7, 8'h07);
        host.wr_reg(3'h7, 8'h43);
        rdc(3'h7, 8'h02);
        rdc(3'h7, 8'h07);
        rdc(3'h7, 8'h02);
        host.wr_reg(3'h1, 8'h40);
        rdc(3'h7, 8'h5A);
        rdc(3'h0, 8'h41);
        rdc(3'h0, 8'h42);
        @(posedge clk) tx_level <= 8'h00;
    endtask

    task automatic t_receive();
        rx_push(8'h11, 1'b0, 1'b0);
        rx_push(8'h22, 1'b1, 1'b0);
        rx_push(8'h33, 1'b0, 1'b1);
        chk(irq_line, 1'b1);
        rdc(3'h5, 8'hE1);
        wait_cyc(1);
        chk(irq_line, 1'b0);
        rdc(3'h0, 8'h11);
        rdc(3'h5, 8'hE5);
        rdc(3'h0, 8'h22);
        rdc(3'h5, 8'hE9);
        rdc(3'h0, 8'h33);
        rdc(3'h5, 8'h60);
        @(posedge clk) rxd <= 1'b0;
        repeat (13)
        begin
            @(posedge clk) bit_tick <= 1'b1;
            @(posedge clk) bit_tick <= 1'b0;
        end
        wait_cyc(3);
        rdc(3'h5, 8'hF9);
        rdc(3'h0, 8'h00);
        rdc(3'h5, 8'h60);
        @(posedge clk) rxd <= 1'b1;
        wait_cyc(3);
    endtask

    task automatic t_modem();
        host.wr_reg(3'h1, 8'h20);
        rdc(3'h6, 8'h00);
        @(posedge clk) cts_n <= 1'b0;
        wait_cyc(4);
        chk(irq_modem, 1'b1);
        rdc(3'h6, 8'h11);
        rdc(3'h6, 8'h10);
        wait_cyc(2);
        chk(irq_modem, 1'b0);
        @(posedge clk) ring_indicator_n <= 1'b0;
        wait_cyc(4);
        rdc(3'h6, 8'h50);
        @(posedge clk) ring_indicator_n <= 1'b1;
        wait_cyc(4);
        rdc(3'h6, 8'h14);
        @(posedge clk) {dsr_n, carrier_detect_n} <= 2'b00;
        wait_cyc(4);
        rdc(3'h6, 8'hBA);
        @(posedge clk) {cts_n, dsr_n, carrier_detect_n} <= 3'b111;
        wait_cyc(4);
        rdc(3'h6, 8'h0B);
        host.wr_reg(3'h1, 8'h02);
        wait_cyc(2);
        chk(tx_halt, 1'b1);
        @(posedge clk) cts_n <= 1'b0;
        wait_cyc(4);
        chk(tx_halt, 1'b0);
        @(posedge clk) cts_n <= 1'b1;
    endtask

    task automatic t_loop();
        logic [7:0] mc [5] = '{8'h1F, 8'h12, 8'h11, 8'h14, 8'h18};
        logic [3:0] ex [5] = '{4'hF, 4'h1, 4'h2, 4'h4, 4'h8};
        logic [7:0] v;
        for (int i = 0; i < 5; i++)
        begin
            host.wr_reg(3'h4, mc[i]);
            host.rd_reg(3'h6, v);
            chk(v[7:4], ex[i]);
        end
        chk({rts_n, dtr_n}, 8'h03);
        host.wr_reg(3'h4, 8'h03);
        wait_cyc(2);
        chk({rts_n, dtr_n}, 8'h00);
        host.wr_reg(3'h4, 8'h00);
    endtask

    task automatic t_transmit();
        @(posedge clk) tx_level <= 8'h03;
        wait_cyc(2);
        rdc(3'h5, 8'h00);
        @(posedge clk);
        tx_level <= 8'h00;
        tx_busy  <= 1'b1;
        wait_cyc(2);
        rdc(3'h5, 8'h20);
        host.wr_reg(3'h1, 8'h18);
        host.wr_reg(3'h7, 8'h00);
        wait_cyc(2);
        chk(rts_n, 1'b0);
        host.wr_reg(3'h7, 8'h08);
        wait_cyc(2);
        chk(rts_n, 1'b1);
        @(posedge clk) tx_busy <= 1'b0;
        wait_cyc(2);
        chk(rts_n, 1'b0);
        host.wr_reg(3'h7, 8'h00);
        wait_cyc(2);
        chk(rts_n, 1'b1);
        host.wr_reg(3'h1, 8'h14);
        host.wr_reg(3'h7, 8'h04);
        host.wr_reg(3'h0, 8'hA5);
        #1;
        chk({tx_write, tx_direct}, 8'h03);
        chk(tx_data, 8'hA5);
        @(posedge clk) tx_done <= 1'b1;
        @(posedge clk) tx_done <= 1'b0;
        host.wr_reg(3'h0, 8'h3C);
        #1;
        chk({tx_write, tx_direct}, 8'h02);
    endtask

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        {rx_valid, rx_parity_err, rx_frame_err, bit_tick, tx_busy, tx_done} = 6'h00;
        {rxd, cts_n, dsr_n, ring_indicator_n, carrier_detect_n} = 5'h1F;
        rx_char    = 8'h00;
        tx_level   = 8'h00;
        frame_bits = 4'hA;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_level();
        t_receive();
        t_modem();
        t_loop();
        t_transmit();
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule

// >>> dv/ulms_chk.sv
// port assertions for the status block
`timescale 1ns/1ps
module ulms_chk (
    input wire logic       clk,              // core clock
    input wire logic       rst,              // sync reset
    input wire logic [2:0] addr,             // address
    input wire logic [7:0] wdata,            // write data
    input wire logic       wr,               // write strobe
    input wire logic       rd,               // read strobe
    input wire logic [7:0] rdata,            // read data
    input wire logic [7:0] tx_level,         // tx fifo count
    input wire logic       tx_busy,          // shifter busy
    input wire logic       cts_n,            // modem pin
    input wire logic       dsr_n,            // modem pin
    input wire logic       ring_indicator_n, // modem pin
    input wire logic       carrier_detect_n, // modem pin
    input wire logic       tx_write,         // byte pulse
    input wire logic       tx_direct,        // bypass pulse
    input wire logic [7:0] tx_data,          // host byte
    input wire logic       tx_halt,          // tx stop
    input wire logic       rx_enable,        // rx on
    input wire logic       nine_bit_en,      // multidrop
    input wire logic       fast_ir_en,       // fast ir
    input wire logic       rts_n,            // request pin
    input wire logic       dtr_n             // ready pin
);
    // ----------------------------------------
    // shadow of host-written state and of the modem pins
    // ----------------------------------------
    logic [7:0] feat_q;
    logic [7:0] mctl_q;
    logic [7:0] sc_q;
    logic [3:0] pin_q;
    logic [1:0] pin_age;
    wire  [3:0] pins     = {carrier_detect_n, ring_indicator_n, dsr_n, cts_n};
    wire  [1:0] age_next = (pins != pin_q) ? 2'h0 : (pin_age == 2'h3) ? 2'h3 : pin_age + 2'h1;

    always_ff @(posedge clk)
    begin
        pin_q <= pins;
        if (rst)
        begin
            feat_q  <= 8'h00;
            mctl_q  <= 8'h00;
            sc_q    <= 8'hFF;
            pin_age <= 2'h0;
        end
        else
        begin
            pin_age <= age_next;
            if (wr && addr == 3'h1)
                feat_q <= wdata;
            if (wr && addr == 3'h4)
                mctl_q <= wdata;
            if (wr && addr == 3'h7 && !feat_q[4])
                sc_q <= wdata;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_port_enables: assert property (wr && addr == 3'h6 && feat_q[0] |-> ##2
        nine_bit_en == $past(wdata[6], 2) && fast_ir_en == $past(wdata[7], 2)
        && rx_enable == !$past(wdata[5], 2) && (tx_halt || !$past(wdata[4], 2)))
        else $error("port enables not taken from write");
    a_port_locked: assert property (wr && addr == 3'h6 && !feat_q[0] |-> ##2
        $stable({nine_bit_en, fast_ir_en, rx_enable}))
        else $error("port enables changed while locked");
    a_scratch_read: assert property (rd && addr == 3'h7 && !feat_q[4] |=>
        rdata == $past(sc_q))
        else $error("scratch byte read mismatch");
    a_holding_full: assert property (rd && addr == 3'h5 && tx_level != 8'h00
        |=> rdata[6:5] == 2'b00)
        else $error("empty flags set with bytes queued");
    a_tx_busy_clear: assert property (rd && addr == 3'h5 && tx_busy
        |=> !rdata[6])
        else $error("tx empty set while shifter busy");
    a_tx_idle: assert property (rd && addr == 3'h5 && !tx_busy && tx_level == 8'h00
        && !$past(wr) |=> rdata[6:5] == 2'b11)
        else $error("empty flags clear while idle");
    a_status_pins: assert property (rd && addr == 3'h6 && pin_age == 2'h3 && !mctl_q[4]
        |=> rdata[7:4] == ~$past(pins))
        else $error("modem status not inverse of pins");
    a_loop_status: assert property (rd && addr == 3'h6 && mctl_q[4]
        |=> rdata[7:4] == {$past(mctl_q[3]), $past(mctl_q[2]), $past(mctl_q[0]), $past(mctl_q[1])})
        else $error("loopback status mapping wrong");
    a_loop_pins: assert property (mctl_q[4] && $past(mctl_q[4]) |-> rts_n && dtr_n)
        else $error("modem outputs active in loopback");
    a_host_write: assert property (wr && addr == 3'h0 |=> tx_write && tx_data == $past(wdata))
        else $error("host byte not passed on");
    a_direct_write: assert property (tx_direct |-> tx_write)
        else $error("bypass pulse without byte pulse");
endmodule

bind ulms_status_ctrl ulms_chk u_chk (
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .tx_level, .tx_busy, .cts_n, .dsr_n,
    .ring_indicator_n, .carrier_detect_n, .tx_write, .tx_direct, .tx_data, .tx_halt,
    .rx_enable, .nine_bit_en, .fast_ir_en, .rts_n, .dtr_n
);

// >>> dv/ulms_host.sv
// register bus master standing in for the host processor
`timescale 1ns/1ps
module ulms_host (
    input  wire logic       clk,   // core clock
    input  wire logic [7:0] rdata, // read data
    output logic      [2:0] addr,  // address
    output logic      [7:0] wdata, // write data
    output logic            wr,    // write strobe
    output logic            rd     // read strobe
);
    initial
        {addr, wdata, wr, rd} = 13'h0000;

    // one-cycle write, returns on the edge that takes it
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule

// >>> inc/ulms_mem_if.sv
// port bundle between the controller and its tag memory
`timescale 1ns/1ps
interface ulms_mem_if #(parameter int W = 11, parameter int A = 4);
    logic         we;
    logic [A-1:0] waddr;
    logic [W-1:0] wdata;
    logic [A-1:0] raddr;
    logic [W-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> inc/ulms_params.svh
// register offsets, field positions and reset values of the status block
`ifndef ULMS_PARAMS_SVH
`define ULMS_PARAMS_SVH

`define ULMS_OFS_DATA     3'h0
`define ULMS_OFS_FEAT     3'h1
`define ULMS_OFS_MCTL     3'h4
`define ULMS_OFS_LSTAT    3'h5
`define ULMS_OFS_MSTAT    3'h6
`define ULMS_OFS_SCR      3'h7

`define ULMS_SCR_RST      8'hFF
`define ULMS_ZERO8        8'h00

// feature control bits
`define ULMS_F_UNLOCK     0
`define ULMS_F_AUTOCTS    1
`define ULMS_F_FIFOEN     2
`define ULMS_F_AUTO485    3
`define ULMS_F_SWAP       4
`define ULMS_F_MSIEN      5
`define ULMS_F_LSIEN      6

// modem control bits
`define ULMS_M_DTR        0
`define ULMS_M_RTS        1
`define ULMS_M_OP1        2
`define ULMS_M_OP2        3
`define ULMS_M_LOOP       4

// port feature enable bits
`define ULMS_P_TXDIS      4
`define ULMS_P_RXDIS      5
`define ULMS_P_NINE       6
`define ULMS_P_FASTIR     7

// enhanced mode select bits
`define ULMS_E_IMM        2
`define ULMS_E_INV485     3
`define ULMS_E_LSIIMM     6
`define ULMS_E_MASK       8'hCF

`define ULMS_TAG_W        11
`define ULMS_FIFO_DEPTH   16

`endif

// >>> inc/ulms_pkg.sv
// types shared by the status block modules
package ulms_pkg;
    typedef struct packed
    {
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } ulms_tag_t;
endpackage

// >>> verilog/ulms_status_ctrl.sv
// line status, modem status and enhanced control of the serial port
`timescale 1ns/1ps
`include "ulms_params.svh"

module ulms_status_ctrl
    import ulms_pkg::*;
#(
    parameter int DEPTH = `ULMS_FIFO_DEPTH
) (
    input  wire logic       clk,           // core clock
    input  wire logic       rst,           // sync reset, high
    input  wire logic [2:0] addr,          // register address
    input  wire logic [7:0] wdata,         // write data
    input  wire logic       wr,            // write strobe
    input  wire logic       rd,            // read strobe
    output logic      [7:0] rdata,         // read data, next cycle
    input  wire logic       rx_valid,      // receiver char pulse
    input  wire logic [7:0] rx_char,       // received character
    input  wire logic       rx_parity_err, // char parity bad
    input  wire logic       rx_frame_err,  // char stop bit bad
    input  wire logic       rxd,           // receive line pin
    input  wire logic       bit_tick,      // one pulse per bit time
    input  wire logic [3:0] frame_bits,    // bit times per frame
    input  wire logic [7:0] tx_level,      // transmit fifo count
    input  wire logic       tx_busy,       // shifter holds a char
    input  wire logic       tx_done,       // shifter sent a char
    input  wire logic       cts_n,         // clear to send pin
    input  wire logic       dsr_n,         // data set ready pin
    input  wire logic       ring_indicator_n, // ring pin
    input  wire logic       carrier_detect_n, // carrier pin
    output logic            tx_write,      // host byte pulse
    output logic            tx_direct,     // byte to shifter
    output logic      [7:0] tx_data,       // host byte
    output logic            tx_halt,       // stop after current
    output logic            rx_enable,     // receiver on
    output logic            nine_bit_en,   // multidrop mode
    output logic            fast_ir_en,    // quarter bit pulses
    output logic            rts_n,         // request to send pin
    output logic            dtr_n,         // terminal ready pin
    output logic            irq_line,      // line status event
    output logic            irq_modem      // modem status event
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || DEPTH > 128 || (1 << AW) != DEPTH)
            $error("DEPTH must be a power of two from 2 to 128");
    endgenerate

    function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
        hit = (a == o);
    endfunction

    //--------------------------------------------------------------
    // register decode
    //--------------------------------------------------------------
    logic [7:0] feat_reg;
    logic [7:0] mctl_reg;
    logic [7:0] pfe_reg;
    logic [7:0] scr_reg;
    logic [7:0] enhanced_mode_select_reg;

    wire swap     = feat_reg[`ULMS_F_SWAP];
    wire wr_data  = wr && hit(addr, `ULMS_OFS_DATA);
    wire wr_feat  = wr && hit(addr, `ULMS_OFS_FEAT);
    wire wr_mctl  = wr && hit(addr, `ULMS_OFS_MCTL);
    wire wr_pfe   = wr && hit(addr, `ULMS_OFS_MSTAT) && feat_reg[`ULMS_F_UNLOCK];
    wire wr_scr   = wr && hit(addr, `ULMS_OFS_SCR) && !swap;
    wire wr_enhanced_mode_select  = wr && hit(addr, `ULMS_OFS_SCR) && swap;
    wire rd_data  = rd && hit(addr, `ULMS_OFS_DATA);
    wire rd_lstat = rd && hit(addr, `ULMS_OFS_LSTAT);
    wire rd_mstat = rd && hit(addr, `ULMS_OFS_MSTAT);
    wire rd_cnt   = rd && hit(addr, `ULMS_OFS_SCR) && swap;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            feat_reg <= `ULMS_ZERO8;
            mctl_reg <= `ULMS_ZERO8;
            pfe_reg  <= `ULMS_ZERO8;
            scr_reg  <= `ULMS_SCR_RST;
        end
        else
        begin
            if (wr_feat)
                feat_reg <= wdata;
            if (wr_mctl)
                mctl_reg <= wdata;
            if (wr_pfe)
                pfe_reg <= wdata & 8'hF0;
            if (wr_scr)
                scr_reg <= wdata;
        end
    end

    //--------------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1_reg <= 5'h1F;
            sync2_reg <= 5'h1F;
        end
        else
        begin
            sync1_reg <= {rxd, carrier_detect_n, ring_indicator_n, dsr_n, cts_n};
            sync2_reg <= sync1_reg;
        end
    end

    wire       rxd_s  = sync2_reg[4];
    wire [3:0] pins_s = sync2_reg[3:0];

    //--------------------------------------------------------------
    // break detection
    //--------------------------------------------------------------
    logic [3:0] low_ticks_reg;
    logic       brk_active_reg;

    wire [4:0] low_next = {1'b0, low_ticks_reg} + 5'h01;
    wire brk_load = bit_tick && !rxd_s && !brk_active_reg
                    && (low_next >= {1'b0, frame_bits});

    always_ff @(posedge clk)
    begin
        if (rst || rxd_s)
        begin
            low_ticks_reg  <= 4'h0;
            brk_active_reg <= 1'b0;
        end
        else if (brk_load)
            brk_active_reg <= 1'b1;
        else if (bit_tick && !brk_active_reg)
            low_ticks_reg <= low_next[3:0];
    end

    //--------------------------------------------------------------
    // receive fifo with error tags
    //--------------------------------------------------------------
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0]   rcnt_reg;
    logic [AW:0]   ecnt_reg;
    logic          ovr_reg;
    logic          imm_err_reg;

    ulms_mem_if #(.W(`ULMS_TAG_W), .A(AW)) mif ();

    ulms_tag_mem #(.W(`ULMS_TAG_W), .A(AW)) u_mem (
        .clk  (clk),
        .port (mif.mem)
    );

    ulms_tag_t head;
    ulms_tag_t push_word;

    wire rx_on    = !pfe_reg[`ULMS_P_RXDIS];
    wire rx_take  = (rx_valid && rx_on && !brk_active_reg) || brk_load;
    wire full     = (rcnt_reg == DEPTH[AW:0]);
    wire nonempty = (rcnt_reg != '0);
    wire push     = rx_take && !full;
    wire pop      = rd_data && nonempty;
    wire push_err = push && (push_word.brk || push_word.fe || push_word.pe);
    wire head_err = nonempty && (head.brk || head.fe || head.pe);
    wire pop_err  = pop && head_err;

    assign push_word = brk_load ? '{brk: 1'b1, fe: 1'b1, pe: 1'b0, data: 8'h00}
                                : '{brk: 1'b0, fe: rx_frame_err,
                                    pe: rx_parity_err, data: rx_char};
    assign head      = mif.rdata;
    assign mif.we    = push;
    assign mif.waddr = wptr_reg;
    assign mif.wdata = push_word;
    assign mif.raddr = pop ? rptr_reg + 1'b1 : rptr_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            rcnt_reg <= '0;
            ecnt_reg <= '0;
            ovr_reg     <= 1'b0;
            imm_err_reg <= 1'b0;
        end
        else
        begin
            if (push)
                wptr_reg <= wptr_reg + 1'b1;
            if (pop)
                rptr_reg <= rptr_reg + 1'b1;
            rcnt_reg <= rcnt_reg + (AW+1)'(push) - (AW+1)'(pop);
            ecnt_reg <= ecnt_reg + (AW+1)'(push_err) - (AW+1)'(pop_err);
            // status read clears overrun; a new event wins
            ovr_reg     <= (rx_take && full) || (ovr_reg && !rd_lstat);
            imm_err_reg <= push_err || (imm_err_reg && !rd_lstat);
        end
    end

    //--------------------------------------------------------------
    // line status
    //--------------------------------------------------------------
    logic tx_wr_reg;

    wire thr_empty = (tx_level == 8'h00) && !tx_wr_reg;
    wire tx_idle   = thr_empty && !tx_busy;
    wire [7:0] lstat = {ecnt_reg != '0,
                        tx_idle,
                        thr_empty,
                        nonempty && head.brk,
                        nonempty && head.fe,
                        nonempty && head.pe,
                        ovr_reg,
                        nonempty};

    //--------------------------------------------------------------
    // modem status
    //--------------------------------------------------------------
    logic [3:0] ms_prev_reg;
    logic [3:0] delta_reg;

    wire loop = mctl_reg[`ULMS_M_LOOP];
    wire [3:0] ms_now = loop ? {mctl_reg[`ULMS_M_OP2], mctl_reg[`ULMS_M_OP1],
                                mctl_reg[`ULMS_M_DTR], mctl_reg[`ULMS_M_RTS]}
                             : ~pins_s;
    wire [3:0] chg = ms_now ^ ms_prev_reg;
    wire [3:0] delta_set = {chg[3],
                            ms_prev_reg[2] && !ms_now[2],
                            chg[1],
                            chg[0]};

    //--------------------------------------------------------------
    // enhanced mode and level counter
    //--------------------------------------------------------------
    logic alt_tx_reg;
    logic imm_wait_reg;

    wire [1:0] lvl_mode = enhanced_mode_select_reg[1:0];
    wire       lvl_alt  = (lvl_mode == 2'b11);
    wire       lvl_tx   = lvl_alt ? alt_tx_reg : lvl_mode[0];
    wire [7:0] rx_lvl   = 8'(rcnt_reg);
    wire       imm_go   = wr_data && enhanced_mode_select_reg[`ULMS_E_IMM] && feat_reg[`ULMS_F_FIFOEN];
    wire       imm_end  = imm_wait_reg && tx_done;

    always_ff @(posedge clk)
    begin
        if (rst)
            enhanced_mode_select_reg <= `ULMS_ZERO8;
        else if (wr_enhanced_mode_select)
            enhanced_mode_select_reg <= wdata & `ULMS_E_MASK;
        else if (imm_end)
            enhanced_mode_select_reg[`ULMS_E_IMM] <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst || wr_enhanced_mode_select)
            alt_tx_reg <= 1'b0;
        else if (rd_cnt && lvl_alt)
            alt_tx_reg <= !alt_tx_reg;
    end

    //--------------------------------------------------------------
    // read data
    //--------------------------------------------------------------
    wire [7:0] scr_view = swap ? (lvl_tx ? tx_level : rx_lvl) : scr_reg;
    wire [7:0] rd_mux =
        hit(addr, `ULMS_OFS_DATA)  ? (nonempty ? head.data : 8'h00) :
        hit(addr, `ULMS_OFS_FEAT)  ? feat_reg :
        hit(addr, `ULMS_OFS_MCTL)  ? mctl_reg :
        hit(addr, `ULMS_OFS_LSTAT) ? lstat :
        hit(addr, `ULMS_OFS_MSTAT) ? {ms_now, delta_reg} :
        hit(addr, `ULMS_OFS_SCR)   ? scr_view : 8'h00;

    //--------------------------------------------------------------
    // transmit side and pin outputs
    //--------------------------------------------------------------
    wire tx_active = tx_busy || (tx_level != 8'h00) || tx_wr_reg;
    wire inv485    = enhanced_mode_select_reg[`ULMS_E_INV485];
    wire rts_auto  = !(tx_active ^ inv485);
    wire rts_next  = loop ? 1'b1 :
                     feat_reg[`ULMS_F_AUTO485] ? rts_auto : !mctl_reg[`ULMS_M_RTS];
    wire halt_next = pfe_reg[`ULMS_P_TXDIS]
                     || (feat_reg[`ULMS_F_AUTOCTS] && !ms_now[0]);
    wire line_head = enhanced_mode_select_reg[`ULMS_E_LSIIMM] ? imm_err_reg : head_err;
    wire line_next = feat_reg[`ULMS_F_LSIEN] && (ovr_reg || line_head);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata       <= 8'h00;
            imm_wait_reg <= 1'b0;
            ms_prev_reg <= 4'h0;
            delta_reg   <= 4'h0;
            tx_wr_reg   <= 1'b0;
            tx_direct   <= 1'b0;
            tx_data     <= 8'h00;
            tx_halt     <= 1'b0;
            rx_enable   <= 1'b1;
            nine_bit_en <= 1'b0;
            fast_ir_en  <= 1'b0;
            rts_n       <= 1'b1;
            dtr_n       <= 1'b1;
            irq_line    <= 1'b0;
            irq_modem   <= 1'b0;
        end
        else
        begin
            rdata       <= rd ? rd_mux : 8'h00;
            imm_wait_reg <= imm_go || (imm_wait_reg && !tx_done);
            ms_prev_reg <= ms_now;
            delta_reg   <= delta_set | (rd_mstat ? 4'h0 : delta_reg);
            tx_wr_reg   <= wr_data;
            tx_direct   <= imm_go;
            tx_data     <= wr_data ? wdata : tx_data;
            tx_halt     <= halt_next;
            rx_enable   <= rx_on;
            nine_bit_en <= pfe_reg[`ULMS_P_NINE];
            fast_ir_en  <= pfe_reg[`ULMS_P_FASTIR];
            rts_n       <= rts_next;
            dtr_n       <= loop || !mctl_reg[`ULMS_M_DTR];
            irq_line    <= line_next;
            irq_modem   <= feat_reg[`ULMS_F_MSIEN] && (delta_reg != 4'h0);
        end
    end

    assign tx_write = tx_wr_reg;
endmodule

// >>> verilog/ulms_status_ctrl_end.sv
// intentionally empty
`timescale 1ns/1ps

// >>> verilog/ulms_tag_mem.sv
// receive fifo storage with registered read and write-through
`timescale 1ns/1ps
module ulms_tag_mem #(
    parameter int W = 11,
    parameter int A = 4
) (
    input  wire logic   clk,    // core clock
    ulms_mem_if.mem     port    // write and read ports
);
    logic [W-1:0] mem_reg [0:(1<<A)-1];
    logic [W-1:0] rdata_reg;

    always_ff @(posedge clk)
    begin
        if (port.we)
            mem_reg[port.waddr] <= port.wdata;
    end

    // a write to the word being read shows at once
    always_ff @(posedge clk)
    begin
        if (port.we && port.waddr == port.raddr)
            rdata_reg <= port.wdata;
        else
            rdata_reg <= mem_reg[port.raddr];
    end

    assign port.rdata = rdata_reg;
endmodule
